// File: src/sar_pkg.sv
package sar_pkg;

    // Channel select codes
    localparam logic [4:0] CH_PIN_LAST = 5'h05;
    localparam logic [4:0] CH_BANDGAP = 5'h06;
    localparam logic [4:0] CH_REF_HIGH = 5'h1D;
    localparam logic [4:0] CH_REF_LOW = 5'h1E;
    localparam logic [4:0] CH_POWER_OFF = 5'h1F;

    // Reset values of the control fields
    localparam logic [4:0] CHANNEL_RESET = 5'h1F;
    localparam logic [2:0] DIVIDE_RESET = 3'h0;
    localparam logic [1:0] JUSTIFY_RESET = 2'h1;

    // Justification modes
    localparam logic [1:0] JUST_LEFT = 2'h0;
    localparam logic [1:0] JUST_RIGHT = 2'h1;
    localparam logic [1:0] JUST_SIGNED = 2'h2;
    localparam logic [1:0] JUST_TRUNC = 2'h3;

    // Conversion length in converter cycles, start cycle included
    localparam logic [4:0] CONV_CYCLES = 5'h11;
    localparam int NUM_PINS = 6;

endpackage : sar_pkg

// File: src/conv_clock_div.sv
`timescale 1ns/10ps
`default_nettype none

// Turns the chosen source tick into a converter clock enable, divide 2^sel
module conv_clock_div
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    input wire logic src_tick,
    input wire logic [2:0] divide_sel,
    // Enable output
    output logic conv_tick
);

    logic [6:0] cnt_r; // Source ticks seen
    logic [6:0] limit; // Last count before a tick

    assign limit = 7'((8'h01 << divide_sel) - 8'h01);
    assign conv_tick = src_tick && (cnt_r >= limit);

    // Count source ticks; restart aligns the first converter cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 7'h00;
        end else if (restart || conv_tick) begin
            cnt_r <= 7'h00;
        end else if (src_tick) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

endmodule : conv_clock_div
`default_nettype wire

// File: src/sar_adc_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module sar_adc_sequencer
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Status/control register write
    input wire logic scr_wr,
    input wire logic [7:0] scr_wdata,
    // Clock config register write
    input wire logic clk_cfg_wr,
    input wire logic [7:0] clk_cfg_wdata,
    // Result register read strobes
    input wire logic res_high_rd,
    input wire logic res_low_rd,
    // Register read values
    output logic [7:0] scr_rdata,
    output logic [7:0] clk_cfg_rdata,
    output logic [7:0] result_high_reg,
    output logic [7:0] result_low_reg,
    // Clock sources and low-power state
    input wire logic oscillator_tick,
    input wire logic stop_mode,
    // Analog core
    output logic [4:0] channel_select,
    output logic converter_enable,
    output logic sample_strobe,
    input wire logic [9:0] core_result,
    // Shared port pins
    input wire logic [5:0] pin_in,
    input wire logic [5:0] port_data_latch,
    input wire logic [5:0] port_dir,
    output logic [5:0] pin_override,
    output logic [5:0] port_read,
    // Interrupt
    output logic conv_irq
);

    typedef enum {S_IDLE, S_CONV} state_t;

    state_t state_r;
    logic conv_irq_enable; // Interrupt enable bit
    logic continuous_select; // Continuous mode bit
    logic conv_done_flag; // Completion flag
    logic [2:0] clock_divide_select; // Divider field
    logic clock_source_select; // 1 picks oscillator
    logic justify_select_hi;
    logic justify_select_lo;
    logic [4:0] cyc_r; // Converter cycles left
    logic osc_s1_r, osc_s2_r; // Oscillator tick synchroniser (2 stages)
    logic osc_prev_r;
    logic [5:0] pin_s1_r, pin_s2_r; // Pin synchroniser
    logic irq_r;
    logic lock_r; // High read seen, low frozen
    logic stop_s1_r, stop_s2_r;
    logic [7:0] res_hi_r, res_lo_r;

    // Derived controls
    logic [1:0] justify;
    logic osc_edge;
    logic src_tick;
    logic conv_tick;
    logic powered;
    logic restart;
    logic start_ok; // Write that starts a conversion
    logic conv_end;
    logic store_ok;
    logic [7:0] fmt_hi, fmt_lo;
    logic [5:0] sel_onehot;

    assign justify = {justify_select_hi, justify_select_lo};
    assign osc_edge = osc_s2_r && !osc_prev_r;
    assign src_tick = clock_source_select ? osc_edge : 1'b1;
    assign powered = (channel_select != CH_POWER_OFF) && !stop_s2_r;
    assign restart = scr_wr;
    // Judged on the new channel, so a write out of power-off still starts
    assign start_ok = scr_wr && (scr_wdata[4:0] != CH_POWER_OFF) && !stop_s2_r;
    assign conv_end = (state_r == S_CONV) && conv_tick && (cyc_r == 5'h01);
    // Interlock: left/right/signed hold while high read awaits low read; truncated never
    assign store_ok = (justify == JUST_TRUNC) || !lock_r;

    // Oscillator tick is from another domain: two flops then edge detect
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_s1_r <= oscillator_tick;
            osc_s2_r <= osc_s1_r;
            osc_prev_r <= osc_s2_r;
        end
    end

    // Pin and stop synchronisers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            stop_s1_r <= stop_mode;
            stop_s2_r <= stop_s1_r;
        end
    end

    // Converter clock enable; first cycle may be partial
    conv_clock_div u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .restart(restart),
        .src_tick(src_tick),
        .divide_sel(clock_divide_select),
        .conv_tick(conv_tick)
    );

    // Control register fields
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_irq_enable <= 1'b0;
            continuous_select <= 1'b0;
            channel_select <= CHANNEL_RESET;
        end else if (scr_wr) begin
            conv_irq_enable <= scr_wdata[6];
            continuous_select <= scr_wdata[5];
            channel_select <= scr_wdata[4:0];
        end
    end

    // Clock configuration fields
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_divide_select <= DIVIDE_RESET;
            clock_source_select <= 1'b0;
            {justify_select_hi, justify_select_lo} <= JUSTIFY_RESET;
        end else if (clk_cfg_wr) begin
            clock_divide_select <= clk_cfg_wdata[7:5];
            clock_source_select <= clk_cfg_wdata[4];
            {justify_select_hi, justify_select_lo} <= clk_cfg_wdata[3:2];
        end
    end

    // Conversion sequencer: 17 converter cycles counting the partial first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            cyc_r <= 5'h00;
        end else if (start_ok) begin
            state_r <= S_CONV;
            cyc_r <= CONV_CYCLES;
        end else if (!powered || restart) begin
            state_r <= S_IDLE;
            cyc_r <= 5'h00;
        end else begin
            case (state_r)
                S_IDLE: begin
                    state_r <= S_IDLE;
                end
                S_CONV: begin
                    if (conv_end) begin
                        state_r <= continuous_select ? S_CONV : S_IDLE;
                        cyc_r <= CONV_CYCLES - 5'h01;
                    end else if (conv_tick) begin
                        cyc_r <= cyc_r - 5'h01;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Result formatting; core already clamps to 000/3FF
    always_comb begin
        fmt_hi = 8'h00;
        fmt_lo = 8'h00;
        case (justify)
            JUST_LEFT: begin
                fmt_hi = core_result[9:2];
                fmt_lo = {core_result[1:0], 6'h00};
            end
            JUST_RIGHT: begin
                fmt_hi = {6'h00, core_result[9:8]};
                fmt_lo = core_result[7:0];
            end
            JUST_SIGNED: begin
                fmt_hi = {~core_result[9], core_result[8:2]};
                fmt_lo = {core_result[1:0], 6'h00};
            end
            default: begin
                fmt_lo = core_result[9:2];
            end
        endcase
    end

    // Result registers and read interlock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_hi_r <= 8'h00;
            res_lo_r <= 8'h00;
            lock_r <= 1'b0;
        end else begin
            if (conv_end && store_ok) begin
                res_hi_r <= fmt_hi;
                res_lo_r <= fmt_lo;
            end
            if (res_low_rd) begin
                lock_r <= 1'b0;
            end else if (res_high_rd && (justify != JUST_TRUNC)) begin
                lock_r <= 1'b1;
            end
        end
    end

    // Completion flag and interrupt; a completion beats a same-cycle clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_done_flag <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            if (conv_end && !conv_irq_enable) begin
                conv_done_flag <= 1'b1;
            end else if (scr_wr || clk_cfg_wr || res_low_rd) begin
                conv_done_flag <= 1'b0;
            end
            if (conv_end && conv_irq_enable) begin
                irq_r <= 1'b1;
            end else if (scr_wr || res_low_rd) begin
                irq_r <= 1'b0;
            end
        end
    end

    // Port pin override for the selected pin channel
    always_comb begin
        sel_onehot = 6'h00;
        if (channel_select <= CH_PIN_LAST) begin
            sel_onehot[channel_select[2:0]] = 1'b1;
        end
    end

    assign pin_override = sel_onehot;
    assign port_read = (port_dir & port_data_latch) | (~port_dir & pin_s2_r);
    assign converter_enable = powered;
    assign sample_strobe = conv_end;
    assign conv_irq = irq_r;
    assign scr_rdata = {conv_done_flag && !conv_irq_enable, conv_irq_enable,
        continuous_select, channel_select};
    assign clk_cfg_rdata = {clock_divide_select, clock_source_select, justify, 2'h0};
    assign result_high_reg = res_hi_r;
    assign result_low_reg = res_lo_r;

    // Flag is set exactly at a completion with interrupts off
    done_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_end && !conv_irq_enable) |=> conv_done_flag)
        else $error("done flag not set");

    // Interrupt set on completion when enabled
    irq_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_end && conv_irq_enable) |=> conv_irq)
        else $error("irq not raised");

    // Interrupt drops after low read without new completion
    irq_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (res_low_rd && !conv_end) |=> !conv_irq)
        else $error("irq not cleared");

    // Flag reads zero while interrupts enabled
    flag_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_irq_enable |-> !scr_rdata[7])
        else $error("flag visible with irq");

    // Control write starts a conversion
    start_conv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (scr_wr && scr_wdata[4:0] != CH_POWER_OFF && !stop_s2_r) |=>
        (state_r == S_CONV && cyc_r == CONV_CYCLES))
        else $error("conversion not started");

    // Stop abandons conversion
    stop_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_s2_r |=> (state_r == S_IDLE))
        else $error("stop did not abort");

    // Locked low result is not overwritten
    lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lock_r && justify != JUST_TRUNC) |=> $stable(res_lo_r))
        else $error("locked result changed");

    // Selected pin is overridden only for pin channels
    pin_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (channel_select > CH_PIN_LAST) |-> (pin_override == 6'h00))
        else $error("bad pin override");

endmodule : sar_adc_sequencer
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the converter sequencer
module tb_top;
    import sar_pkg::*;

    // Stimulus and observed signals
    logic clk_sys, rst_n, scr_wr, clk_cfg_wr, res_high_rd, res_low_rd, stop_mode;
    logic [7:0] scr_wdata, clk_cfg_wdata, scr_rdata, clk_cfg_rdata, hi, lo;
    logic oscillator_tick = 1'b0;
    logic [4:0] channel_select;
    logic converter_enable, sample_strobe, conv_irq;
    logic [9:0] core_result;
    logic [5:0] pin_in, port_data_latch, port_dir, pin_override, port_read;
    int num_errors = 0;
    int n_tests = 0;
    int n, strobes, osc_cnt = 0;
    logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1D,
        5'h1E, 5'h1F};
    logic [15:0] e;

    sar_adc_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .scr_wr(scr_wr),
        .scr_wdata(scr_wdata), .clk_cfg_wr(clk_cfg_wr), .clk_cfg_wdata(clk_cfg_wdata),
        .res_high_rd(res_high_rd), .res_low_rd(res_low_rd), .scr_rdata(scr_rdata),
        .clk_cfg_rdata(clk_cfg_rdata), .result_high_reg(hi), .result_low_reg(lo),
        .oscillator_tick(oscillator_tick), .stop_mode(stop_mode),
        .channel_select(channel_select), .converter_enable(converter_enable),
        .sample_strobe(sample_strobe), .core_result(core_result), .pin_in(pin_in),
        .port_data_latch(port_data_latch), .port_dir(port_dir),
        .pin_override(pin_override), .port_read(port_read), .conv_irq(conv_irq));

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Slow oscillator source, one rising edge every six cycles
    always @(posedge clk_sys) begin
        osc_cnt <= (osc_cnt == 2) ? 0 : osc_cnt + 1;
        if (osc_cnt == 2) oscillator_tick <= ~oscillator_tick;
    end

    // Counts conversion ends
    always @(posedge clk_sys) begin
        if (sample_strobe === 1'b1) strobes <= strobes + 1;
    end

    // Compare and report
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle write strobes
    task automatic wr_scr(input logic [7:0] d);
        @(posedge clk_sys);
        scr_wr <= 1'b1;
        scr_wdata <= d;
        @(posedge clk_sys);
        scr_wr <= 1'b0;
    endtask : wr_scr

    task automatic wr_clk(input logic [7:0] d);
        @(posedge clk_sys);
        clk_cfg_wr <= 1'b1;
        clk_cfg_wdata <= d;
        @(posedge clk_sys);
        clk_cfg_wr <= 1'b0;
    endtask : wr_clk

    // One-cycle read strobe of the high or low result
    task automatic rd(input bit high);
        @(posedge clk_sys);
        if (high) res_high_rd <= 1'b1;
        else res_low_rd <= 1'b1;
        @(posedge clk_sys);
        res_high_rd <= 1'b0;
        res_low_rd <= 1'b0;
    endtask : rd

    // Counts rising edges from the write edge to the conversion end
    task automatic conv(input logic [9:0] v);
        n = 0;
        do begin
            @(posedge clk_sys);
            core_result <= v;
            n++;
        end while (sample_strobe !== 1'b1 && n < 2000);
        #1;
    endtask : conv

    // Expected {high, low} for a format; truncated mode leaves high at zero
    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
        case (m)
            JUST_LEFT: fmt = {v[9:2], v[1:0], 6'h00};
            JUST_RIGHT: fmt = {6'h00, v};
            JUST_SIGNED: fmt = {~v[9], v[8:2], v[1:0], 6'h00};
            default: fmt = {8'h00, v[9:2]};
        endcase
    endfunction : fmt

    // Verdict and end of run
    task automatic end_of_test;
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        {rst_n, scr_wr, clk_cfg_wr, res_high_rd, res_low_rd, stop_mode} = '0;
        {scr_wdata, clk_cfg_wdata, core_result} = '0;
        {pin_in, port_data_latch, port_dir} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        check("scr reset", scr_rdata, 10'h01F);
        check("clk reset", clk_cfg_rdata, 10'h004);
        check("enable reset", converter_enable, 1'b0);
        // Channel map and pin override
        foreach (codes[i]) begin
            wr_scr({3'h0, codes[i]});
            #1;
            check("override", pin_override, (codes[i] < 6) ? 10'(1 << codes[i]) : 10'h0);
            check("channel", channel_select, codes[i]);
            check("enable", converter_enable, codes[i] != 5'h1F);
        end
        // Port reads of the selected pin
        wr_scr(8'h02);
        port_dir <= 6'h04;
        port_data_latch <= 6'h04;
        repeat (4) @(posedge clk_sys);
        #1;
        check("read latch", port_read, 10'h004);
        check("override hold", pin_override, 10'h004);
        @(posedge clk_sys);
        port_dir <= 6'h00;
        port_data_latch <= 6'h00;
        pin_in <= 6'h04;
        repeat (4) @(posedge clk_sys);
        #1;
        check("read pin", port_read, 10'h004);
        // Single conversion, flag set and cleared
        wr_clk(8'h04);
        wr_scr(8'h02);
        conv(10'h2A5);
        check("cycles", n[9:0], 10'd17);
        check("flag set", scr_rdata, 10'h082);
        rd(1'b0);
        #1;
        check("flag low rd", scr_rdata, 10'h002);
        // Restart in mid conversion, then clock write clears flag
        wr_scr(8'h02);
        repeat (5) @(posedge clk_sys);
        wr_scr(8'h02);
        conv(10'h3FF);
        check("restart", n[9:0], 10'd17);
        wr_clk(8'h04);
        #1;
        check("flag clk wr", scr_rdata, 10'h002);
        // Every format; trunc follows a high read with no interlock
        for (int m = 0; m < 4; m++) begin
            wr_clk({4'h0, m[1:0], 2'h0});
            #1;
            check("clk cfg", clk_cfg_rdata, {4'h0, m[1:0], 2'h0});
            e = fmt(m[1:0], 10'h2D6);
            rd(1'b1);
            rd(1'b0);
            if (m == 3) rd(1'b1);
            wr_scr(8'h02);
            conv(10'h2D6);
            check("res high", hi, e[15:8]);
            check("res low", lo, e[7:0]);
        end
        // Interlock in left and right modes
        for (int m = 0; m < 2; m++) begin
            wr_clk({4'h0, m[1:0], 2'h0});
            wr_scr(8'h02);
            conv(10'h155);
            rd(1'b1);
            e = fmt(m[1:0], 10'h155);
            wr_scr(8'h02);
            conv(10'h2AA);
            check("lock high", hi, e[15:8]);
            check("lock low", lo, e[7:0]);
            rd(1'b0);
            wr_scr(8'h02);
            conv(10'h2AA);
            e = fmt(m[1:0], 10'h2AA);
            check("unlock low", lo, e[7:0]);
        end
        // Interrupt request and its clearing
        wr_clk(8'h04);
        wr_scr(8'h42);
        conv(10'h011);
        check("irq set", conv_irq, 1'b1);
        check("flag hidden", scr_rdata, 10'h042);
        rd(1'b0);
        #1;
        check("irq low rd", conv_irq, 1'b0);
        wr_scr(8'h42);
        conv(10'h011);
        wr_scr(8'h02);
        #1;
        check("irq scr wr", conv_irq, 1'b0);
        // Continuous mode overwrites unread data
        wr_scr(8'h22);
        conv(10'h111);
        conv(10'h222);
        check("cont period", n[9:0], 10'd16);
        check("cont data", lo, 10'h022);
        wr_scr(8'h02);
        conv(10'h000);
        // Divided bus clock and oscillator source
        wr_clk(8'h24);
        wr_scr(8'h02);
        conv(10'h000);
        check("div two", (n >= 32 && n <= 38), 1'b1);
        wr_clk(8'h14);
        wr_scr(8'h02);
        conv(10'h000);
        check("osc src", (n >= 90 && n <= 125), 1'b1);
        // Stop mode abandons the conversion
        wr_clk(8'h04);
        wr_scr(8'h02);
        repeat (4) @(posedge clk_sys);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        n = strobes;
        // Window reaches past the end the aborted conversion would have had
        repeat (150) @(posedge clk_sys);
        #1;
        check("stop idle", 10'(strobes - n), 10'd0);
        check("stop enable", converter_enable, 1'b0);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        repeat (17) @(posedge clk_sys);
        wr_scr(8'h02);
        conv(10'h3FF);
        check("resume", n[9:0], 10'd17);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
